// >>> rsm_regs.vh
// Purpose: Named constants of the reset source and memory remap block.
// Assumes: Byte addresses on a 32-bit linear map.
// Notes: Definitions only.
`ifndef RSM_REGS_VH
`define RSM_REGS_VH

// Register byte addresses.
`define RSM_REMAP_ADDR 32'hFFFF_0220
`define RSM_STAT_ADDR 32'hFFFF_0230
`define RSM_CLR_ADDR 32'hFFFF_0234
`define RSM_LAT_ADDR 32'hFFFF_0238

// Field positions.
`define RSM_REMAP_BIT 0
`define RSM_NOLDM_BIT 0
`define RSM_POR_BIT 0
`define RSM_WDT_BIT 1
`define RSM_SW_BIT 2
`define RSM_EXT_BIT 3
`define RSM_STAT_W 4
`define RSM_STAT_POR 4'h1

// Memory map.
`define RSM_ALIAS_END 32'h0001_7800
`define RSM_SRAM_BASE 32'h0004_0000
`define RSM_SRAM_SIZE 32'h0000_1800
`define RSM_SRAM_END 32'h0004_1800
`define RSM_SRAM_WORDS 1536
`define RSM_FLASH_BASE 32'h0008_0000
`define RSM_KERN_BASE 32'h0009_7800
`define RSM_FLASH_END 32'h0009_8000
`define RSM_MMR_BASE 32'hFFFF_0000
`define RSM_MMR_END 32'hFFFF_1000

// Region codes.
`define RSM_RGN_ABORT 2'h0
`define RSM_RGN_SRAM 2'h1
`define RSM_RGN_FLASH 2'h2
`define RSM_RGN_MMR 2'h3

// Access sizes.
`define RSM_SZ_BYTE 2'h0
`define RSM_SZ_HALF 2'h1

// Interrupt entry.
`define RSM_FIQ_VEC 32'h0000_001C
`define RSM_IRQ_VEC 32'h0000_0018
`define RSM_LAT_MAX 8'h32
`define RSM_LAT_NOLDM 8'h2A
`define RSM_LAT_COMP 8'h16
`define RSM_LAT_MIN 8'h05
`define RSM_LAT_SYNC 8'h03

// System reset pulse length in core cycles.
`define RSM_SYSRST_LEN 4'h8

`endif

// >>> rsm_sram.v
// Purpose: 1536 x 32 on-chip SRAM with byte enables.
// Assumes: Index already range-checked by the decoder.
// Notes: One full word per access; read data one cycle after enable.
`timescale 1ns/1ps
`include "rsm_regs.vh"

module rsm_sram
(
   // Clock.
   input wire core_clk,
   input wire clkEn,
   // Access.
   input wire en,
   input wire we,
   input wire [3:0] be,
   input wire [10:0] index,
   input wire [31:0] wdata,
   output reg [31:0] rdata
);

   reg [31:0] mem [0:`RSM_SRAM_WORDS-1];
   integer i;

   // Contents are not reset so that they survive non power-on resets.
   always @(posedge core_clk)
   begin
      if (clkEn && en)
      begin
         if (we)
         begin
            for (i = 0; i < 4; i = i + 1)
            begin
               if (be[i])
               begin
                  mem[index][i*8 +: 8] <= wdata[i*8 +: 8];
               end
            end
         end
         rdata <= mem[index];
      end
   end

endmodule // rsm_sram

// >>> rsm_sysctl.v
// Purpose: Address decoder, memory remap, reset cause tracking and interrupt entry timing.
// Assumes: APB register access; core bus requests come from logic on core_clk.
// Notes: Flash and peripheral accesses leave over the ext port and are answered there.
`timescale 1ns/1ps
`include "rsm_regs.vh"

// Function
// - Accesses outside every defined region raise a data abort.
// - Multi-byte data is little endian, low byte at lowest address.
// - SRAM is 1536 words of 32 bits at 0x00040000, code or data.
// - SRAM takes byte, halfword and word accesses, full word per cycle.
// - The low 94 kB alias either nonvolatile memory or SRAM.
// - A 4 kB register area near the top holds all peripheral registers.
// - Exception vectors at the bottom come from the aliased memory.
// - After reset nonvolatile memory is aliased at address zero.
// - Remap bit 0 at 0xFFFF0220 selects SRAM at zero; clear selects nonvolatile.
// - Every reset clears the remap selection.
// - Reset runs hidden kernel first; user code cannot reach its 2 kB.
// - Reset cause register at 0xFFFF0230 accumulates every reset source until its bits are cleared.
// - External reset sets bit 3, watchdog bit 1, power-on bit 0.
// - Cause bits 7..4 always read zero.
// - Writing 1 to cause bit 2 makes a software reset and sets it.
// - Clear register at 0xFFFF0234 clears cause bits written as one.
// - With bit 2 set, a clear write not clearing it resets again.
// - SRAM invalid after reset following download; kept after other resets except power-on, which takes lvfRamOk.
// - Fast interrupt reaches vector 0x1C within 50 cycles.
// - Entry limit drops to 42 without load-multiple, 22 in compressed mode.
// - Interrupt entry never takes fewer than five cycles.
// - The first handler instruction runs in 32-bit mode.
module rsm_sysctl
(
   // Clock, reset and enable.
   input wire core_clk,
   input wire resetn,
   input wire clkEn,
   // APB register slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Core memory bus.
   input wire memReq,
   input wire memWrite,
   input wire [1:0] memSize,
   input wire [31:0] memAddr,
   input wire [31:0] memWdata,
   output reg memDone,
   output reg memAbort,
   output reg [31:0] memRdata,
   // Flash and peripheral target.
   output reg extReq,
   output reg extMmr,
   output reg extWrite,
   output reg [1:0] extSize,
   output reg [31:0] extAddr,
   output reg [31:0] extWdata,
   input wire extAck,
   input wire [31:0] extRdata,
   // Reset sources and status.
   input wire extResetN,
   input wire wdtTimeout,
   input wire downloadDone,
   input wire lvfRamOk,
   input wire kernelDone,
   output reg sysResetN,
   output reg kernelActive,
   output reg sramValid,
   output reg remapSram,
   // Interrupt entry.
   input wire fiqPin,
   input wire irqPin,
   input wire coreInstrDone,
   input wire coreCompressed,
   output reg vecTake,
   output reg [31:0] vecAddr,
   output reg vecArmMode
);

   localparam B_IDLE = 2'h0;
   localparam B_SRAM = 2'h1;
   localparam B_EXT = 2'h2;
   localparam I_IDLE = 2'h0;
   localparam I_WAIT = 2'h1;
   localparam I_HOLD = 2'h2;

   reg rstMeta;
   reg rstn;
   reg [2:0] pinMeta;
   reg [2:0] pinSync;
   reg extPrev;
   reg porPend;
   reg dlPend;
   reg [3:0] rstCnt;
   reg [`RSM_STAT_W-1:0] cause;
   reg noLdm;
   reg [1:0] busState;
   reg [1:0] reqLo;
   reg [1:0] reqSize;
   reg [1:0] irqState;
   reg isFiq;
   reg [7:0] latCnt;
   reg [31:0] next_prdata;
   reg addrHit;

   wire fiqSync = pinSync[1];
   wire irqSync = pinSync[0];
   wire extLow = !pinSync[2];
   wire extEvt = extLow && extPrev;
   wire apbAcc = psel && penable;
   wire apbWr = apbAcc && pready && pwrite && addrHit;
   wire wrStat = apbWr && (paddr == `RSM_STAT_ADDR);
   wire wrClr = apbWr && (paddr == `RSM_CLR_ADDR);
   wire swSet = wrStat && pwdata[`RSM_SW_BIT];
   wire swAgain = wrClr && cause[`RSM_SW_BIT] && !pwdata[`RSM_SW_BIT];
   wire swEvt = swSet || swAgain;
   wire sysEvt = extEvt || wdtTimeout || swEvt;
   wire [1:0] rgn = regionOf(memAddr, remapSram, kernelActive);
   wire busTake = (busState == B_IDLE) && memReq && !memDone;
   wire sramEn = busTake && (rgn == `RSM_RGN_SRAM);
   wire [31:0] sramRdata;
   wire [7:0] latNext = latCnt + 8'h01;

   // Decodes a core address; the alias window follows the remap bit only.
   function [1:0] regionOf;
      input [31:0] a;
      input rm;
      input kern;
      begin
         regionOf = `RSM_RGN_ABORT;
         if (a < `RSM_ALIAS_END)
         begin
            if (!rm)
               regionOf = `RSM_RGN_FLASH;
            else if (a < `RSM_SRAM_SIZE)
               regionOf = `RSM_RGN_SRAM;
         end
         else if (a >= `RSM_SRAM_BASE && a < `RSM_SRAM_END)
            regionOf = `RSM_RGN_SRAM;
         else if (a >= `RSM_FLASH_BASE && a < `RSM_KERN_BASE)
            regionOf = `RSM_RGN_FLASH;
         else if (a >= `RSM_KERN_BASE && a < `RSM_FLASH_END && kern)
            regionOf = `RSM_RGN_FLASH;
         else if (a >= `RSM_MMR_BASE && a < `RSM_MMR_END)
            regionOf = `RSM_RGN_MMR;
      end
   endfunction

   // Byte lanes of an access, least significant byte at the lowest address.
   function [3:0] byteEn;
      input [1:0] sz;
      input [1:0] lo;
      begin
         case (sz)
            `RSM_SZ_BYTE: byteEn = 4'h1 << lo;
            `RSM_SZ_HALF: byteEn = lo[1] ? 4'hC : 4'h3;
            default: byteEn = 4'hF;
         endcase
      end
   endfunction

   // Moves read data from its lanes down to bit 0 and masks to the size.
   function [31:0] laneOut;
      input [31:0] d;
      input [1:0] lo;
      input [1:0] sz;
      reg [31:0] s;
      begin
         s = d >> {lo, 3'b000};
         case (sz)
            `RSM_SZ_BYTE: laneOut = s & 32'h0000_00FF;
            `RSM_SZ_HALF: laneOut = s & 32'h0000_FFFF;
            default: laneOut = s;
         endcase
      end
   endfunction

   // Worst-case entry limit for the current core mode.
   function [7:0] latLimit;
      input comp;
      input nl;
      begin
         if (comp)
            latLimit = `RSM_LAT_COMP;
         else if (nl)
            latLimit = `RSM_LAT_NOLDM;
         else
            latLimit = `RSM_LAT_MAX;
      end
   endfunction

   rsm_sram u_sram
   (
      .core_clk(core_clk),
      .clkEn(clkEn),
      .en(sramEn),
      .we(memWrite),
      .be(byteEn(memSize, memAddr[1:0])),
      .index(memAddr[12:2]),
      .wdata(memWdata << {memAddr[1:0], 3'b000}),
      .rdata(sramRdata)
   );

   // Reset release synchroniser; assertion stays asynchronous.
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rstMeta <= 1'b0;
         rstn <= 1'b0;
      end
      else if (clkEn)
      begin
         rstMeta <= 1'b1;
         rstn <= rstMeta;
      end
   end

   // Pins from outside the clock domain pass two flip-flops.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pinMeta <= 3'h4;
         pinSync <= 3'h4;
         extPrev <= 1'b0;
      end
      else if (clkEn)
      begin
         pinMeta <= {extResetN, fiqPin, irqPin};
         pinSync <= pinMeta;
         extPrev <= !extLow;
      end
   end

   // System reset pulse then kernel run; power-on and every other source come here.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         porPend <= 1'b1;
         rstCnt <= 4'h0;
         sysResetN <= 1'b0;
         kernelActive <= 1'b0;
      end
      else if (clkEn)
      begin
         porPend <= 1'b0;
         if (porPend || sysEvt)
         begin
            rstCnt <= `RSM_SYSRST_LEN;
            sysResetN <= 1'b0;
            kernelActive <= 1'b0;
         end
         else if (rstCnt != 4'h0)
         begin
            rstCnt <= rstCnt - 4'h1;
            if (rstCnt == 4'h1)
            begin
               sysResetN <= 1'b1;
               kernelActive <= 1'b1;
            end
         end
         else if (kernelDone)
            kernelActive <= 1'b0;
      end
   end

   // Cause bits: hardware set wins over a clear in the same cycle.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cause <= `RSM_STAT_POR;
      else if (clkEn)
      begin
         cause <= (cause & ~(wrClr ? pwdata[`RSM_STAT_W-1:0] : 4'h0))
                  | {extEvt, swEvt, wdtTimeout, 1'b0};
      end
   end

   // Remap and entry-limit control; every reset restores the nonvolatile alias.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         remapSram <= 1'b0;
         noLdm <= 1'b0;
      end
      else if (clkEn)
      begin
         if (sysEvt)
            remapSram <= 1'b0;
         else if (apbWr && paddr == `RSM_REMAP_ADDR)
            remapSram <= pwdata[`RSM_REMAP_BIT];
         if (apbWr && paddr == `RSM_LAT_ADDR)
            noLdm <= pwdata[`RSM_NOLDM_BIT];
      end
   end

   // SRAM validity is judged once per reset; a pending download spoils it.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dlPend <= 1'b0;
         sramValid <= 1'b0;
      end
      else if (clkEn)
      begin
         if (porPend)
            sramValid <= lvfRamOk;
         else if (sysEvt)
            sramValid <= !dlPend;
         if (downloadDone)
            dlPend <= 1'b1;
         else if (sysEvt)
            dlPend <= 1'b0;
      end
   end

   // Register read mux; bits above the fields read as zero.
   always @*
   begin
      addrHit = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
         `RSM_REMAP_ADDR: next_prdata[`RSM_REMAP_BIT] = remapSram;
         `RSM_STAT_ADDR: next_prdata[`RSM_STAT_W-1:0] = cause;
         `RSM_CLR_ADDR: next_prdata = 32'h0000_0000;
         `RSM_LAT_ADDR: next_prdata[`RSM_NOLDM_BIT] = noLdm;
         default: addrHit = 1'b0;
      endcase
   end

   // APB answers with one wait state; writes land on the ready edge.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (clkEn)
      begin
         pready <= apbAcc && !pready;
         if (apbAcc && !pready)
         begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= !addrHit;
         end
         else
         begin
            pslverr <= 1'b0;
         end
      end
   end

   // Core bus: one request in flight; SRAM answers in two cycles, ext on ack.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         busState <= B_IDLE;
         reqLo <= 2'h0;
         reqSize <= 2'h0;
         memDone <= 1'b0;
         memAbort <= 1'b0;
         memRdata <= 32'h0000_0000;
         extReq <= 1'b0;
         extMmr <= 1'b0;
         extWrite <= 1'b0;
         extSize <= 2'h0;
         extAddr <= 32'h0000_0000;
         extWdata <= 32'h0000_0000;
      end
      else if (clkEn)
      begin
         memDone <= 1'b0;
         memAbort <= 1'b0;
         case (busState)
            B_IDLE:
            begin
               if (memReq && !memDone)
               begin
                  reqLo <= memAddr[1:0];
                  reqSize <= memSize;
                  case (rgn)
                     `RSM_RGN_SRAM: busState <= B_SRAM;
                     `RSM_RGN_ABORT:
                     begin
                        memDone <= 1'b1;
                        memAbort <= 1'b1;
                        memRdata <= 32'h0000_0000;
                     end
                     default:
                     begin
                        busState <= B_EXT;
                        extReq <= 1'b1;
                        extMmr <= (rgn == `RSM_RGN_MMR);
                        extWrite <= memWrite;
                        extSize <= memSize;
                        extWdata <= memWdata;
                        // Aliased flash goes out at its absolute address.
                        extAddr <= (memAddr < `RSM_ALIAS_END) ? memAddr + `RSM_FLASH_BASE : memAddr;
                     end
                  endcase
               end
            end
            B_SRAM:
            begin
               memDone <= 1'b1;
               memRdata <= laneOut(sramRdata, reqLo, reqSize);
               busState <= B_IDLE;
            end
            B_EXT:
            begin
               if (extAck)
               begin
                  extReq <= 1'b0;
                  memDone <= 1'b1;
                  memRdata <= extRdata;
                  busState <= B_IDLE;
               end
            end
            default: busState <= B_IDLE;
         endcase
      end
   end

   // Interrupt entry: count from request, take the vector between the bounds.
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqState <= I_IDLE;
         isFiq <= 1'b0;
         latCnt <= 8'h00;
         vecTake <= 1'b0;
         vecAddr <= 32'h0000_0000;
         vecArmMode <= 1'b0;
      end
      else if (clkEn)
      begin
         vecTake <= 1'b0;
         vecArmMode <= 1'b0;
         case (irqState)
            I_IDLE:
            begin
               if (fiqSync || irqSync)
               begin
                  isFiq <= fiqSync;
                  latCnt <= `RSM_LAT_SYNC;
                  irqState <= I_WAIT;
               end
            end
            I_WAIT:
            begin
               latCnt <= latNext;
               // A fast request overtakes a pending normal one.
               if (fiqSync)
                  isFiq <= 1'b1;
               if ((latNext >= `RSM_LAT_MIN && coreInstrDone)
                   || latNext >= latLimit(coreCompressed, noLdm))
               begin
                  vecTake <= 1'b1;
                  vecAddr <= (isFiq || fiqSync) ? `RSM_FIQ_VEC : `RSM_IRQ_VEC;
                  vecArmMode <= 1'b1;
                  irqState <= I_HOLD;
               end
            end
            I_HOLD:
            begin
               if (!fiqSync && !irqSync)
                  irqState <= I_IDLE;
            end
            default: irqState <= I_IDLE;
         endcase
      end
   end

endmodule // rsm_sysctl

// >>> rsm_props.sv
// Purpose: Port checks for the system control block.
// Assumes: The core bus master holds its address until memDone.
// Notes: Interrupt latency is counted in cycles from the pin.
`timescale 1ns/1ps
`include "rsm_regs.vh"
module rsm_props
(
   // Clock and reset.
   input wire core_clk,
   input wire resetn,
   // Register and memory buses.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire [31:0] prdata,
   input wire memReq,
   input wire [31:0] memAddr,
   input wire memDone,
   input wire memAbort,
   input wire extReq,
   input wire extMmr,
   input wire [31:0] extAddr,
   // Reset and interrupt.
   input wire sysResetN,
   input wire remapSram,
   input wire fiqPin,
   input wire irqPin,
   input wire vecTake,
   input wire [31:0] vecAddr,
   input wire vecArmMode
);
   reg [7:0] latCnt;
   reg held;
   wire apbWr = psel & penable & pready & pwrite;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   always @(posedge core_clk or negedge resetn)
      if (!resetn)
      begin
         latCnt <= 8'h00;
         held <= 1'b0;
      end
      else
      begin
         held <= (fiqPin | irqPin) & (held | vecTake);
         latCnt <= !(fiqPin | irqPin) ? 8'h00 : (held ? latCnt : latCnt + 8'h01);
      end
   property p_abortGap; memDone && memAddr >= `RSM_SRAM_END && memAddr < `RSM_FLASH_BASE |-> memAbort; endproperty
   a_abortGap: assert property (p_abortGap) else $error("no abort in gap");
   property p_sramTime; $rose(memReq) && memAddr >= `RSM_SRAM_BASE && memAddr < `RSM_SRAM_END
      |-> ##[2:3] (memDone && !memAbort); endproperty
   a_sramTime: assert property (p_sramTime) else $error("sram answer late");
   property p_flashAbs; extReq && !extMmr |-> extAddr >= `RSM_FLASH_BASE && extAddr < `RSM_FLASH_END; endproperty
   a_flashAbs: assert property (p_flashAbs) else $error("flash address not absolute");
   property p_remapWr; apbWr && paddr == `RSM_REMAP_ADDR |=> remapSram == $past(pwdata[0]); endproperty
   a_remapWr: assert property (p_remapWr) else $error("remap bit not taken");
   property p_remapClr; !sysResetN |-> !remapSram; endproperty
   a_remapClr: assert property (p_remapClr) else $error("remap kept in reset");
   property p_statHigh; pready && !pwrite && paddr == `RSM_STAT_ADDR |-> prdata[31:4] == 28'h000_0000; endproperty
   a_statHigh: assert property (p_statHigh) else $error("status high bits set");
   property p_swReset; apbWr && paddr == `RSM_STAT_ADDR && pwdata[2] |-> ##[1:4] !sysResetN; endproperty
   a_swReset: assert property (p_swReset) else $error("no software reset");
   property p_latency; vecTake |-> latCnt >= 8'h05 && latCnt <= 8'h32; endproperty
   a_latency: assert property (p_latency) else $error("bad latency");
   property p_vecFast; vecTake && fiqPin |-> vecAddr == `RSM_FIQ_VEC && vecArmMode; endproperty
   a_vecFast: assert property (p_vecFast) else $error("bad fast vector");
   c_abort: cover property (memDone && memAbort);
   c_vec: cover property (vecTake);
   c_sysrst: cover property ($fell(sysResetN));
endmodule // rsm_props

bind rsm_sysctl rsm_props props_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .prdata, .memReq, .memAddr, .memDone, .memAbort, .extReq, .extMmr, .extAddr, .sysResetN, .remapSram,
   .fiqPin, .irqPin, .vecTake, .vecAddr, .vecArmMode);

// >>> rsm_ext_model.sv
// Purpose: Flash and peripheral target on the ext port.
// Assumes: One request at a time, held until extAck.
// Notes: Read data is the address with a key.
`timescale 1ns/1ps
module rsm_ext_model
(
   // Clock and reset.
   input wire core_clk,
   input wire resetn,
   // Target port.
   input wire extReq,
   input wire [31:0] extAddr,
   input wire slow,
   output reg extAck,
   output reg [31:0] extRdata
);
   reg [2:0] waitCnt;
   always @(posedge core_clk or negedge resetn)
      if (!resetn)
      begin
         extAck <= 1'b0;
         waitCnt <= 3'h0;
         extRdata <= 32'h0000_0000;
      end
      else if (extReq && !extAck && waitCnt >= {slow, 2'h0})
      begin
         extAck <= 1'b1;
         waitCnt <= 3'h0;
         extRdata <= extAddr ^ 32'h5A5A_0000;
      end
      else
      begin
         extAck <= 1'b0;
         waitCnt <= (extReq && !extAck) ? waitCnt + 3'h1 : 3'h0;
         extRdata <= extRdata + 32'h1357_9BDF;
      end
endmodule // rsm_ext_model

// >>> tb_reset_source_and_memory_remap.sv
// Purpose: Self-checking bench for the system control block.
// Assumes: APB and core bus driven just after rising edges.
// Notes: The ext side is answered by rsm_ext_model.
`timescale 1ns/1ps
`include "rsm_regs.vh"
module tb_reset_source_and_memory_remap;
   reg core_clk, resetn, clkEn, psel, penable, pwrite, memReq, memWrite, extResetN, wdtTimeout;
   reg downloadDone, lvfRamOk, kernelDone, fiqPin, irqPin, coreInstrDone, coreCompressed, slow, ab;
   reg [1:0] memSize;
   reg [31:0] paddr, pwdata, memAddr, memWdata, rd;
   wire pready, pslverr, memDone, memAbort, extReq, extMmr, extWrite, extAck, sysResetN;
   wire kernelActive, sramValid, remapSram, vecTake, vecArmMode;
   wire [1:0] extSize;
   wire [31:0] prdata, memRdata, extAddr, extWdata, extRdata, vecAddr;
   integer num_errors, total_checks, i, n, lim;

   rsm_sysctl dut_u (.core_clk, .resetn, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .memReq, .memWrite, .memSize, .memAddr, .memWdata, .memDone, .memAbort, .memRdata, .extReq,
      .extMmr, .extWrite, .extSize, .extAddr, .extWdata, .extAck, .extRdata, .extResetN, .wdtTimeout,
      .downloadDone, .lvfRamOk, .kernelDone, .sysResetN, .kernelActive, .sramValid, .remapSram, .fiqPin,
      .irqPin, .coreInstrDone, .coreCompressed, .vecTake, .vecAddr, .vecArmMode);
   rsm_ext_model ext_u (.core_clk, .resetn, .extReq, .extAddr, .slow, .extAck, .extRdata);

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task check(input string nm, input [31:0] seen, input [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task apb(input w, input [31:0] a, input [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n = n + 1)
         @(posedge core_clk);
      check("pready", pready, 1);
      rd = prdata;
      ab = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task rdr(input [31:0] a, input [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check("register", rd, e);
   endtask

   task mem(input w, input [1:0] sz, input [31:0] a, input [31:0] d);
      memReq <= 1'b1;
      memWrite <= w;
      memSize <= sz;
      memAddr <= a;
      memWdata <= d;
      for (n = 0; n < 20 && memDone !== 1'b1; n = n + 1)
         @(posedge core_clk);
      check("memDone", memDone, 1);
      rd = memRdata;
      ab = memAbort;
      memReq <= 1'b0;
      @(posedge core_clk);
   endtask

   task mrd(input [1:0] sz, input [31:0] a, input [31:0] e, input ea);
      mem(1'b0, sz, a, 32'h0000_0000);
      check("memAbort", ab, ea);
      if (!ea)
         check("memRdata", rd, e);
   endtask

   task sysWait;
      for (n = 0; n < 8 && sysResetN !== 1'b0; n = n + 1)
         @(posedge core_clk);
      check("sysLow", sysResetN, 0);
      for (n = 0; n < 30 && sysResetN !== 1'b1; n = n + 1)
         @(posedge core_clk);
      @(posedge core_clk);
      check("kernel", kernelActive, 1);
      kernelDone <= 1'b1;
      @(posedge core_clk);
      kernelDone <= 1'b0;
      repeat (2) @(posedge core_clk);
      check("kernelEnd", kernelActive, 0);
   endtask

   task pulseWdt;
      wdtTimeout <= 1'b1;
      @(posedge core_clk);
      wdtTimeout <= 1'b0;
      sysWait;
   endtask

   initial
   begin
      #100000;
      num_errors = num_errors + 1;
      stop_test;
   end

   initial
   begin
      {resetn, psel, penable, pwrite, memReq, memWrite, wdtTimeout, downloadDone, kernelDone} = 9'h000;
      {fiqPin, irqPin, coreInstrDone, coreCompressed, slow, memSize} = 7'h00;
      {clkEn, lvfRamOk, extResetN} = 3'h7;
      {paddr, pwdata, memAddr, memWdata} = 128'h0;
      num_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      sysWait;
      rdr(`RSM_STAT_ADDR, 32'h0000_0001);
      rdr(`RSM_REMAP_ADDR, 32'h0000_0000);
      check("sramValid", sramValid, 1);
      apb(1'b0, 32'hFFFF_0300, 32'h0000_0000);
      check("pslverr", ab, 1);
      $display("test reset done");
      mem(1'b1, 2'h2, `RSM_SRAM_BASE, 32'h4433_2211);
      for (i = 0; i < 4; i = i + 1)
         mrd(`RSM_SZ_BYTE, `RSM_SRAM_BASE + i, 32'h11 * (i + 1), 0);
      mem(1'b1, 2'h2, `RSM_SRAM_BASE + 4, 32'h0000_0000);
      mem(1'b1, `RSM_SZ_HALF, `RSM_SRAM_BASE + 6, 32'h0000_BEEF);
      mrd(2'h2, `RSM_SRAM_BASE + 4, 32'hBEEF_0000, 0);
      mem(1'b1, 2'h2, `RSM_SRAM_END - 4, 32'hCAFE_0123);
      mrd(2'h2, `RSM_SRAM_END - 4, 32'hCAFE_0123, 0);
      mrd(2'h2, `RSM_SRAM_END, 0, 1);
      mrd(2'h2, `RSM_ALIAS_END, 0, 1);
      mrd(2'h2, `RSM_KERN_BASE, 0, 1);
      mrd(2'h2, `RSM_MMR_END, 0, 1);
      mrd(2'h2, 32'hFFFF_0E08, 32'hA5A5_0E08, 0);
      $display("test map done");
      slow <= 1'b1;
      mrd(2'h2, 32'h0000_0004, 32'h5A52_0004, 0);
      apb(1'b1, `RSM_REMAP_ADDR, 32'h0000_0001);
      rdr(`RSM_REMAP_ADDR, 32'h0000_0001);
      mrd(2'h2, 32'h0000_0000, 32'h4433_2211, 0);
      mrd(2'h2, `RSM_FLASH_BASE, 32'h5A52_0000, 0);
      mrd(2'h2, `RSM_SRAM_BASE, 32'h4433_2211, 0);
      slow <= 1'b0;
      $display("test remap done");
      pulseWdt;
      check("remapSram", remapSram, 0);
      rdr(`RSM_STAT_ADDR, 32'h0000_0003);
      mrd(2'h2, `RSM_SRAM_BASE, 32'h4433_2211, 0);
      apb(1'b1, `RSM_CLR_ADDR, 32'h0000_0003);
      rdr(`RSM_STAT_ADDR, 32'h0000_0000);
      apb(1'b1, `RSM_REMAP_ADDR, 32'h0000_0001);
      extResetN <= 1'b0;
      repeat (3) @(posedge core_clk);
      extResetN <= 1'b1;
      sysWait;
      check("remapSram", remapSram, 0);
      rdr(`RSM_STAT_ADDR, 32'h0000_0008);
      apb(1'b1, `RSM_STAT_ADDR, 32'h0000_0004);
      sysWait;
      rdr(`RSM_STAT_ADDR, 32'h0000_000C);
      apb(1'b1, `RSM_CLR_ADDR, 32'h0000_0008);
      sysWait;
      rdr(`RSM_STAT_ADDR, 32'h0000_0004);
      apb(1'b1, `RSM_CLR_ADDR, 32'h0000_0004);
      for (i = 0; i < 12; i = i + 1)
      begin
         @(posedge core_clk);
         check("noReset", sysResetN, 1);
      end
      downloadDone <= 1'b1;
      @(posedge core_clk);
      downloadDone <= 1'b0;
      pulseWdt;
      check("sramValid", sramValid, 0);
      $display("test causes done");
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(1'b1, `RSM_LAT_ADDR, i == 2);
         lim = (i == 0) ? 50 : (i == 1) ? 22 : (i == 2) ? 42 : 8;
         coreCompressed <= (i == 1);
         coreInstrDone <= (i == 3);
         fiqPin <= (i != 3);
         irqPin <= (i == 3);
         for (n = 0; n < 80 && vecTake !== 1'b1; n = n + 1)
            @(posedge core_clk);
         check("vecAddr", vecAddr, (i == 3) ? `RSM_IRQ_VEC : `RSM_FIQ_VEC);
         check("vecArmMode", vecArmMode, 1);
         check("latMax", n - 1 <= lim, 1);
         check("latMin", n - 1 >= lim - 3, 1);
         fiqPin <= 1'b0;
         irqPin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      $display("test entry done");
      stop_test;
   end
endmodule // tb_reset_source_and_memory_remap
